// ---- hw/discrete_io_pkg.sv ----
// constants shared by the dual discrete i/o port block
// assumes a 32-bit apb register bus and 8-bit ports
package discrete_io_pkg;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_E_FUNC = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_F_FUNC = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_E_DIR = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_F_DIR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_E_DATA_A = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_F_DATA_A = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_E_DATA_B = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_F_DATA_B = 8'h1c;
  localparam int E_GAP_BIT = 3;
  localparam logic [PORT_W-1:0] RST_FUNC = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR = 8'h00;
  localparam logic [PORT_W-1:0] RST_DATA = 8'h00;
  // missing pin: function bit reads one, others read zero
  localparam logic [PORT_W-1:0] E_GAP_MASK = 8'h08;
endpackage : discrete_io_pkg

// ---- hw/dual_port_discrete_io.sv ----
// two 8-bit discrete i/o ports with per-pin function select, behind apb
// assumes pins are outside the clock domain; bus-control side comes in as ports
// Operation
// R1: sixteen pins, two ports, per-pin configuration
// R2: port e data bit three reads zero
// R3: function bit one selects bus control
// R4: port e function bit three reads one
// R5: direction one drives, zero is input
// R6: port e direction bit three reads zero
// R7: direction and data always readable, writable
// R8: data write latches, outputs drive latch
// R9: discrete inputs read live pin level
// R10: each data register at two addresses
// R11: bus-control pins ignore direction and latch
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dual_port_discrete_io (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [discrete_io_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [discrete_io_pkg::PORT_W-1:0] port_e_pin_in,
  input wire logic [discrete_io_pkg::PORT_W-1:0] port_f_pin_in,
  output logic [discrete_io_pkg::PORT_W-1:0] port_e_pin_out,
  output logic [discrete_io_pkg::PORT_W-1:0] port_f_pin_out,
  output logic [discrete_io_pkg::PORT_W-1:0] port_e_pin_oe_n_out,
  output logic [discrete_io_pkg::PORT_W-1:0] port_f_pin_oe_n_out,
  input wire logic [discrete_io_pkg::PORT_W-1:0] port_e_ctrl_out_in,
  input wire logic [discrete_io_pkg::PORT_W-1:0] port_f_ctrl_out_in,
  input wire logic [discrete_io_pkg::PORT_W-1:0] port_e_ctrl_oe_in,
  input wire logic [discrete_io_pkg::PORT_W-1:0] port_f_ctrl_oe_in,
  output logic [discrete_io_pkg::PORT_W-1:0] port_e_ctrl_in_out,
  output logic [discrete_io_pkg::PORT_W-1:0] port_f_ctrl_in_out
);
  import discrete_io_pkg::*;

  logic [PORT_W-1:0] e_func_ff;
  logic [PORT_W-1:0] f_func_ff;
  logic [PORT_W-1:0] e_dir_ff;
  logic [PORT_W-1:0] f_dir_ff;
  logic [PORT_W-1:0] e_lat_ff;
  logic [PORT_W-1:0] f_lat_ff;
  logic [PORT_W-1:0] e_meta_ff;
  logic [PORT_W-1:0] f_meta_ff;
  logic [PORT_W-1:0] e_sync_ff;
  logic [PORT_W-1:0] f_sync_ff;
  logic [31:0] prdata_ff;

  wire access = psel_in & penable_in;
  wire wr_ok = access & pwrite_in & pstrb_in[0];
  wire rd_ok = access & ~pwrite_in;
  wire hit_e_func = paddr_in == OFF_E_FUNC;
  wire hit_f_func = paddr_in == OFF_F_FUNC;
  wire hit_e_dir = paddr_in == OFF_E_DIR;
  wire hit_f_dir = paddr_in == OFF_F_DIR;
  wire hit_e_data = (paddr_in == OFF_E_DATA_A) | (paddr_in == OFF_E_DATA_B); // R10
  wire hit_f_data = (paddr_in == OFF_F_DATA_A) | (paddr_in == OFF_F_DATA_B); // R10
  wire mapped = hit_e_func | hit_f_func | hit_e_dir | hit_f_dir | hit_e_data | hit_f_data;
  wire [PORT_W-1:0] wbyte = pwdata_in[PORT_W-1:0];

  // visible register values with the missing port e pin folded in
  wire [PORT_W-1:0] e_func_vis = e_func_ff | E_GAP_MASK; // R4
  wire [PORT_W-1:0] e_dir_vis = e_dir_ff & ~E_GAP_MASK; // R6
  wire [PORT_W-1:0] e_lat_vis = e_lat_ff & ~E_GAP_MASK; // R2
  // discrete-input pins read the synchronised pin, all else the latch
  wire [PORT_W-1:0] e_in_sel = ~e_func_vis & ~e_dir_vis;
  wire [PORT_W-1:0] f_in_sel = ~f_func_ff & ~f_dir_ff;
  wire [PORT_W-1:0] e_data_rd = ((e_sync_ff & e_in_sel) | (e_lat_vis & ~e_in_sel)) & ~E_GAP_MASK; // R9 R2
  wire [PORT_W-1:0] f_data_rd = (f_sync_ff & f_in_sel) | (f_lat_ff & ~f_in_sel); // R9

  wire [PORT_W-1:0] rd_byte = hit_e_func ? e_func_vis :
                              hit_f_func ? f_func_ff :
                              hit_e_dir ? e_dir_vis :
                              hit_f_dir ? f_dir_ff :
                              hit_e_data ? e_data_rd :
                              hit_f_data ? f_data_rd : 8'h00;

  assign pready_out = 1'b1;
  assign pslverr_out = access & ~mapped;
  assign prdata_out = prdata_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      prdata_ff <= {24'h00_0000, rd_byte};
    end
  end

  // configuration and data latches, writable whatever the pin state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      e_func_ff <= RST_FUNC;
      f_func_ff <= RST_FUNC;
      e_dir_ff <= RST_DIR;
      f_dir_ff <= RST_DIR;
      e_lat_ff <= RST_DATA;
      f_lat_ff <= RST_DATA;
    end else if (wr_ok) begin
      if (hit_e_func) e_func_ff <= wbyte & ~E_GAP_MASK; // R3 R4
      if (hit_f_func) f_func_ff <= wbyte; // R3
      if (hit_e_dir) e_dir_ff <= wbyte & ~E_GAP_MASK; // R6 R7
      if (hit_f_dir) f_dir_ff <= wbyte; // R7
      if (hit_e_data) e_lat_ff <= wbyte & ~E_GAP_MASK; // R8 R2
      if (hit_f_data) f_lat_ff <= wbyte; // R8
    end
  end

  // two-flop pin synchronisers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      e_meta_ff <= 8'h00;
      f_meta_ff <= 8'h00;
      e_sync_ff <= 8'h00;
      f_sync_ff <= 8'h00;
    end else begin
      e_meta_ff <= port_e_pin_in;
      f_meta_ff <= port_f_pin_in;
      e_sync_ff <= e_meta_ff;
      f_sync_ff <= f_meta_ff;
    end
  end

  // per-pin mux between bus-control function and discrete i/o
  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : g_pin // R1
      assign port_e_pin_out[g] = e_func_vis[g] ? port_e_ctrl_out_in[g] : e_lat_vis[g]; // R3 R8 R11
      assign port_f_pin_out[g] = f_func_ff[g] ? port_f_ctrl_out_in[g] : f_lat_ff[g]; // R3 R8 R11
      assign port_e_pin_oe_n_out[g] = e_func_vis[g] ? ~port_e_ctrl_oe_in[g] : ~e_dir_vis[g]; // R5 R11
      assign port_f_pin_oe_n_out[g] = f_func_ff[g] ? ~port_f_ctrl_oe_in[g] : ~f_dir_ff[g]; // R5 R11
    end
  endgenerate
  assign port_e_ctrl_in_out = e_sync_ff;
  assign port_f_ctrl_in_out = f_sync_ff;

  wire wr_e_data = wr_ok & hit_e_data;
  wire wr_f_dir = wr_ok & hit_f_dir;
  wire wr_e_func = wr_ok & hit_e_func;
  wire wr_f_func = wr_ok & hit_f_func;
  wire wr_e_dir = wr_ok & hit_e_dir;
  wire rd_setup = psel_in & ~penable_in & ~pwrite_in;

  // single-cycle bus conditions used by the properties below
  sequence f_data_write_seq;
    wr_ok && hit_f_data;
  endsequence
  sequence rd_setup_seq;
    psel_in && !penable_in && !pwrite_in;
  endsequence

  chk_gap_reads_fixed: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
    e_data_rd[E_GAP_BIT] == 1'b0 && e_dir_vis[E_GAP_BIT] == 1'b0)
    else $error("port e bit three not zero");
  chk_gap_func_one: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    wr_e_func |=> e_func_vis[E_GAP_BIT] && port_e_pin_out[E_GAP_BIT] == port_e_ctrl_out_in[E_GAP_BIT])
    else $error("port e function bit three not one");
  chk_func_selects: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
    f_func_ff[0] |-> port_f_pin_out[0] == port_f_ctrl_out_in[0])
    else $error("bus-control pin not routed");
  chk_dir_drives: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    wr_f_dir && !f_func_ff[1] |=> port_f_pin_oe_n_out[1] == !$past(pwdata_in[1]))
    else $error("direction write not on driver");
  chk_dir_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    wr_f_dir |=> f_dir_ff == $past(pwdata_in[PORT_W-1:0]))
    else $error("direction write lost");
  chk_latch_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    wr_e_data && !e_func_vis[0] |=> port_e_pin_out[0] == $past(pwdata_in[0]))
    else $error("latched data not on pin");
  sequence input_pin_seq;
    !f_func_ff[2] && !f_dir_ff[2] && hit_f_data;
  endsequence
  chk_live_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    input_pin_seq |-> rd_byte[2] == f_sync_ff[2])
    else $error("input pin not read live");
  chk_alias_same: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    wr_ok && paddr_in == OFF_F_DATA_B |=> f_lat_ff == $past(pwdata_in[PORT_W-1:0]))
    else $error("alias write missed latch");
  chk_ctrl_isolate: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
    f_func_ff[4] |-> port_f_pin_oe_n_out[4] == !port_f_ctrl_oe_in[4])
    else $error("direction leaks onto bus-control pin");

  // bus answer and read path
  chk_ready_high: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    pready_out == 1'b1)
    else $error("slave not ready");
  chk_err_unmapped: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    access && !mapped |-> pslverr_out)
    else $error("unmapped access without error");
  chk_err_mapped: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    mapped |-> !pslverr_out)
    else $error("error on mapped register");
  chk_err_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    !access |-> !pslverr_out)
    else $error("error outside access phase");
  chk_rd_upper_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    prdata_out[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  chk_rd_capture: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    rd_setup_seq |=> prdata_out == {24'h00_0000, $past(rd_byte)})
    else $error("read data not captured at setup");
  chk_rd_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    !rd_setup |=> $stable(prdata_out))
    else $error("read data moved between reads");
  chk_wr_no_rd_load: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    psel_in && !penable_in && pwrite_in |=> $stable(prdata_out))
    else $error("write setup disturbed read data");
  chk_unmapped_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    rd_setup && !mapped |=> prdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rd_e_func: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    rd_setup && hit_e_func |=> prdata_out[PORT_W-1:0] == $past(e_func_vis))
    else $error("port e function read wrong");
  chk_rd_f_func: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
    rd_setup && hit_f_func |=> prdata_out[PORT_W-1:0] == $past(f_func_ff))
    else $error("port f function read wrong");
  chk_rd_e_dir: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
    rd_setup && hit_e_dir |=> prdata_out[PORT_W-1:0] == $past(e_dir_vis))
    else $error("port e direction read wrong");
  chk_rd_f_dir: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    rd_setup && hit_f_dir |=> prdata_out[PORT_W-1:0] == $past(f_dir_ff))
    else $error("port f direction read wrong");
  chk_rd_e_data: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    rd_setup && hit_e_data |=> prdata_out[PORT_W-1:0] == $past(e_data_rd))
    else $error("port e data read wrong");
  chk_rd_f_data: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    rd_setup && hit_f_data |=> prdata_out[PORT_W-1:0] == $past(f_data_rd))
    else $error("port f data read wrong");

  // register writes
  chk_e_func_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
    wr_e_func |=> e_func_ff == ($past(wbyte) & ~E_GAP_MASK))
    else $error("port e function write lost");
  chk_f_func_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
    wr_f_func |=> f_func_ff == $past(wbyte))
    else $error("port f function write lost");
  chk_f_func_full: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    wr_f_func |=> f_func_ff[E_GAP_BIT] == $past(wbyte[E_GAP_BIT]))
    else $error("port f bit three not writable");
  chk_f_dir_full: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    wr_f_dir |=> f_dir_ff[E_GAP_BIT] == $past(wbyte[E_GAP_BIT]))
    else $error("port f direction bit three not writable");
  chk_e_dir_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    wr_e_dir |=> e_dir_vis == ($past(wbyte) & ~E_GAP_MASK))
    else $error("port e direction write lost");
  chk_e_lat_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    wr_e_data |=> e_lat_vis == ($past(wbyte) & ~E_GAP_MASK))
    else $error("port e latch write lost");
  chk_f_lat_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    f_data_write_seq |=> f_lat_ff == $past(wbyte))
    else $error("port f latch write lost");
  chk_alias_e: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    wr_ok && paddr_in == OFF_E_DATA_B |=> e_lat_vis == ($past(wbyte) & ~E_GAP_MASK))
    else $error("port e alias write missed latch");
  chk_alias_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    paddr_in == OFF_F_DATA_A || paddr_in == OFF_F_DATA_B |-> rd_byte == f_data_rd)
    else $error("port f alias reads differ");
  chk_lat_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    !wr_ok |=> $stable(e_lat_ff) && $stable(f_lat_ff))
    else $error("latch moved without write");
  chk_cfg_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    !wr_ok |=> $stable(e_func_ff) && $stable(f_func_ff) && $stable(e_dir_ff) && $stable(f_dir_ff))
    else $error("configuration moved without write");
  chk_err_no_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    access && !mapped |=> $stable(e_lat_ff) && $stable(f_lat_ff) && $stable(e_func_ff) && $stable(f_dir_ff))
    else $error("unmapped write changed a register");
  chk_strobe_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    access && pwrite_in && !pstrb_in[0] |=> $stable(e_lat_ff) && $stable(f_lat_ff))
    else $error("write without lane zero landed");

  // missing port e pin
  chk_gap_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
    e_lat_ff[E_GAP_BIT] == 1'b0)
    else $error("port e latch bit three set");
  chk_gap_dir_ff: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
    e_dir_ff[E_GAP_BIT] == 1'b0)
    else $error("port e direction bit three set");
  chk_gap_pin_route: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    port_e_pin_oe_n_out[E_GAP_BIT] == !port_e_ctrl_oe_in[E_GAP_BIT])
    else $error("port e bit three enable not bus-control");

  // two-flop pin synchronisers
  chk_e_meta: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    $past(rst_n_in) |-> e_meta_ff == $past(port_e_pin_in))
    else $error("port e first sync stage wrong");
  chk_f_meta: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    $past(rst_n_in) |-> f_meta_ff == $past(port_f_pin_in))
    else $error("port f first sync stage wrong");
  chk_e_sync: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    $past(rst_n_in) |-> e_sync_ff == $past(e_meta_ff))
    else $error("port e second sync stage wrong");
  chk_f_sync: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    $past(rst_n_in) |-> f_sync_ff == $past(f_meta_ff))
    else $error("port f second sync stage wrong");

  // per-pin routing, one set for each pin of both ports
  generate
    for (g = 0; g < PORT_W; g++) begin : g_pin_chk
      chk_e_func_route: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        e_func_vis[g] |-> port_e_pin_out[g] == port_e_ctrl_out_in[g])
        else $error("port e bus-control value not routed");
      chk_e_func_oe: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
        e_func_vis[g] |-> port_e_pin_oe_n_out[g] == !port_e_ctrl_oe_in[g])
        else $error("port e bus-control enable not routed");
      chk_e_io_oe: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        !e_func_vis[g] |-> port_e_pin_oe_n_out[g] == !e_dir_vis[g])
        else $error("port e direction not on driver");
      chk_e_io_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        !e_func_vis[g] |-> port_e_pin_out[g] == e_lat_vis[g])
        else $error("port e latch not on pin");
      chk_f_func_route: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        f_func_ff[g] |-> port_f_pin_out[g] == port_f_ctrl_out_in[g])
        else $error("port f bus-control value not routed");
      chk_f_func_oe: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
        f_func_ff[g] |-> port_f_pin_oe_n_out[g] == !port_f_ctrl_oe_in[g])
        else $error("port f bus-control enable not routed");
      chk_f_io_oe: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        !f_func_ff[g] |-> port_f_pin_oe_n_out[g] == !f_dir_ff[g])
        else $error("port f direction not on driver");
      chk_f_io_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        !f_func_ff[g] |-> port_f_pin_out[g] == f_lat_ff[g])
        else $error("port f latch not on pin");
      chk_e_in_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
        !e_func_vis[g] && !e_dir_vis[g] |-> e_data_rd[g] == e_sync_ff[g])
        else $error("port e input not read live");
      chk_e_lat_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
        e_func_vis[g] || e_dir_vis[g] |-> e_data_rd[g] == e_lat_vis[g])
        else $error("port e latch not read back");
      chk_f_in_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
        !f_func_ff[g] && !f_dir_ff[g] |-> f_data_rd[g] == f_sync_ff[g])
        else $error("port f input not read live");
      chk_f_lat_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
        f_func_ff[g] || f_dir_ff[g] |-> f_data_rd[g] == f_lat_ff[g])
        else $error("port f latch not read back");
    end
  endgenerate
endmodule : dual_port_discrete_io
`default_nettype wire

// ---- sim/dual_port_discrete_io_tb.sv ----
// self-checking bench: apb reads note their expected result in a queue, a monitor compares
// assumes the package, the block and pin_board are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", n, e, s); end end
module dual_port_discrete_io_tb;
  import discrete_io_pkg::*;
  logic clk_in = 0;
  logic rst_n_in = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [7:0] ext_e = 0, ext_f = 0, c_out_e = 0, c_out_f = 0, c_oe_e = 0, c_oe_f = 0;
  logic [7:0] lvl_e, lvl_f, pout_e, pout_f, oen_e, oen_f, r, d, ci_e, ci_f;
  logic [32:0] q[$];
  logic [32:0] got;
  int n_fail = 0;
  int compares = 0;
  int seed = 28;
  always #4 clk_in = ~clk_in;
  pin_board brd_e (.drv_in(pout_e), .oe_n_in(oen_e), .ext_in(ext_e), .level_out(lvl_e));
  pin_board brd_f (.drv_in(pout_f), .oe_n_in(oen_f), .ext_in(ext_f), .level_out(lvl_f));
  dual_port_discrete_io dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .port_e_pin_in(lvl_e), .port_f_pin_in(lvl_f),
    .port_e_pin_out(pout_e), .port_f_pin_out(pout_f), .port_e_pin_oe_n_out(oen_e),
    .port_f_pin_oe_n_out(oen_f), .port_e_ctrl_out_in(c_out_e), .port_f_ctrl_out_in(c_out_f),
    .port_e_ctrl_oe_in(c_oe_e), .port_f_ctrl_oe_in(c_oe_f), .port_e_ctrl_in_out(ci_e), .port_f_ctrl_in_out(ci_f));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_in);
    pen <= 1;
    do @(posedge clk_in); while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic err, input logic [7:0] e);
    q.push_back({err, 24'h0, e});
    apb(0, a, 32'h0);
  endtask : rd
  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_in) begin
    if (psel && pen && (pready === 1'b1) && !pwr) begin
      got = q.pop_front();
      `CMP("read", got, {pslverr, prdata})
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1;
    rd(OFF_E_FUNC, 0, 8'h08);
    rd(OFF_E_DIR, 0, 8'h00);
    $display("reset reads done");
    c_out_e <= 8'($random(seed));
    c_oe_e <= 8'($random(seed));
    apb(1, OFF_E_FUNC, 32'hff);
    apb(1, OFF_E_DIR, 32'hff);
    apb(1, OFF_E_DATA_A, 32'hff);
    rd(OFF_E_FUNC, 0, 8'hff);
    rd(OFF_E_DIR, 0, 8'hf7);
    rd(OFF_E_DATA_B, 0, 8'hf7);
    `CMP("e_pins", c_out_e, pout_e)
    `CMP("e_oe_n", ~c_oe_e, oen_e)
    $display("function mode done");
    r = 8'($random(seed));
    apb(1, OFF_E_FUNC, 32'h0);
    apb(1, OFF_F_DIR, 32'hff);
    apb(1, OFF_E_DATA_B, {24'h0, r});
    apb(1, OFF_F_DATA_A, {24'h0, ~r});
    rd(OFF_F_DATA_B, 0, ~r);
    `CMP("e_out", r & 8'hf7, pout_e & 8'hf7)
    `CMP("f_out", ~r, pout_f)
    `CMP("f_oe_n", 8'h00, oen_f)
    $display("output mode done");
    d = 8'($random(seed)) & 8'hfb;
    ext_f <= 8'($random(seed));
    ext_e <= 8'($random(seed));
    apb(1, OFF_F_DIR, {24'h0, d});
    apb(1, OFF_E_DIR, 32'h0);
    repeat (3) @(posedge clk_in);
    rd(OFF_F_DATA_A, 0, (~r & d) | (ext_f & ~d));
    rd(OFF_E_DATA_A, 0, ext_e & 8'hf7);
    rd(8'h20, 1, 8'h00);
    $display("input mode done");
    c_out_f <= 8'($random(seed));
    c_oe_f <= 8'($random(seed));
    apb(1, OFF_F_FUNC, 32'hff);
    repeat (3) @(posedge clk_in);
    rd(OFF_F_DATA_A, 0, ~r);
    `CMP("f_pins", c_out_f, pout_f)
    `CMP("f_oe_n", ~c_oe_f, oen_f)
    `CMP("f_ctrl_in", lvl_f, ci_f)
    `CMP("e_ctrl_in", lvl_e, ci_e)
    $display("bus-control mode done");
    print_verdict();
  end
  initial begin
    repeat (2000) @(posedge clk_in);
    n_fail++;
    print_verdict();
  end
endmodule : dual_port_discrete_io_tb
`default_nettype wire

// ---- sim/pin_board.sv ----
// board side of one port: each pin resolves to the block's drive or an external level
// assumes active-low enables, low meaning the block drives
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic [7:0] drv_in,
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] level_out
);
  assign level_out = (drv_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule : pin_board
`default_nettype wire
